// file: rtl/sfc_defines.vh
// Constants for the serial flash command front end: opcodes, frame bit positions,
// status layout and protection limits. Definitions only; included by bare name.
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

`define SFC_OP_CONT_RD    8'h68
`define SFC_OP_CONT_RD03  8'hE8
`define SFC_OP_PAGE_RD    8'h52
`define SFC_OP_PAGE_RD03  8'hD2
`define SFC_OP_B1_RD      8'h54
`define SFC_OP_B1_RD03    8'hD4
`define SFC_OP_B2_RD      8'h56
`define SFC_OP_B2_RD03    8'hD6
`define SFC_OP_STAT_RD    8'h57
`define SFC_OP_STAT_RD03  8'hD7
`define SFC_OP_B1_WR      8'h84
`define SFC_OP_B2_WR      8'h87
`define SFC_OP_B1_PGM_E   8'h83
`define SFC_OP_B2_PGM_E   8'h86
`define SFC_OP_B1_PGM     8'h88
`define SFC_OP_B2_PGM     8'h89
`define SFC_OP_PAGE_ERASE 8'h81
`define SFC_OP_BLK_ERASE  8'h50
`define SFC_OP_B1_LDPGM   8'h82
`define SFC_OP_B2_LDPGM   8'h85
`define SFC_OP_B1_XFER    8'h53
`define SFC_OP_B2_XFER    8'h55
`define SFC_OP_B1_CMP     8'h60
`define SFC_OP_B2_CMP     8'h61
`define SFC_OP_B1_REWR    8'h58
`define SFC_OP_B2_REWR    8'h59

// Bit counts within a frame at which each phase begins, and the count at which the bit counter stops.
`define SFC_OP_BITS       7'd8
`define SFC_CMD_BITS      7'd32
`define SFC_BUF_RD_START  7'd40
`define SFC_ARR_RD_START  7'd64
`define SFC_BITCNT_MAX    7'd127

// Address field positions in the 24 bits after the opcode; the protect bits are positions within the page field.
`define SFC_PAGE_MSB      22
`define SFC_PAGE_LSB      10
`define SFC_COL_MSB       9
`define SFC_COL_LSB       0
`define SFC_PROT_MSB      12
`define SFC_PROT_LSB      8

// Status byte layout.
`define SFC_ST_READY      7
`define SFC_ST_CMP        6

`endif

// file: rtl/sfc_front_end.v
// Serial flash command front end: pin sampling, opcode decode, buffer access,
// array operation scheduling, busy pin and status byte, plus its byte FIFO.
// Assumes one 50 MHz clock; all pins are asynchronous and are synchronised here.
// The array engine sits outside on the same clock and answers start with done.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"

// Byte FIFO between the serial shifter and the buffer memory.
module sfc_fifo
#(
   parameter W     = 19,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire         mclk_i,
   input  wire         rst_i,
   input  wire [W-1:0] in_data_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   output wire [W-1:0] out_data_o,
   output wire         out_valid_o,
   input  wire         out_ready_i
);
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0]   cnt_q;
   wire         push;
   wire         pop;

   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Pointers wrap at the depth; the count gives honest full and empty.
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   // Storage has no reset; only written entries are ever read.
   always @(posedge mclk_i)
   begin
      if (push)
         mem_q[wr_q] <= in_data_i;
   end
endmodule

module sfc_front_end
#(
   parameter BUF_BYTES   = 528,
   parameter FIFO_DEPTH  = 8,
   parameter [5:0] ST_LOW_BITS = 6'h00   // Arbitrary value for the low status bits.
)
(
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        cs_n_i,
   input  wire        sck_i,
   input  wire        si_i,
   input  wire        wp_n_i,
   input  wire        reset_n_i,
   output reg         so_o,
   output reg         so_oe_n_o,
   output reg         rdy_o,
   output reg         rdy_oe_n_o,
   output reg         mode3_o,
   output reg         arr_start_o,
   output reg  [7:0]  arr_cmd_o,
   output reg  [12:0] arr_page_o,
   output reg  [9:0]  arr_col_o,
   output reg         arr_buf_o,
   output reg         arr_rd_o,
   output reg         arr_rnext_o,
   input  wire [7:0]  arr_rdata_i,
   input  wire        arr_done_i,
   input  wire        arr_match_i
);
   localparam FW = 19;

   // Opcode classes; is_wr_op and op_buf are used in more than one place.
   function is_busy_op;   // Array operations that hold the busy pin.
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_B1_PGM_E, `SFC_OP_B2_PGM_E, `SFC_OP_B1_PGM, `SFC_OP_B2_PGM,
            `SFC_OP_PAGE_ERASE, `SFC_OP_BLK_ERASE, `SFC_OP_B1_LDPGM, `SFC_OP_B2_LDPGM,
            `SFC_OP_B1_XFER, `SFC_OP_B2_XFER, `SFC_OP_B1_CMP, `SFC_OP_B2_CMP,
            `SFC_OP_B1_REWR, `SFC_OP_B2_REWR: is_busy_op = 1'b1;
            default: is_busy_op = 1'b0;
         endcase
      end
   endfunction

   function is_prog_op;   // Operations that alter the array.
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_B1_PGM_E, `SFC_OP_B2_PGM_E, `SFC_OP_B1_PGM, `SFC_OP_B2_PGM,
            `SFC_OP_PAGE_ERASE, `SFC_OP_BLK_ERASE, `SFC_OP_B1_LDPGM, `SFC_OP_B2_LDPGM,
            `SFC_OP_B1_REWR, `SFC_OP_B2_REWR: is_prog_op = 1'b1;
            default: is_prog_op = 1'b0;
         endcase
      end
   endfunction

   function is_wr_op;     // Operations whose data bytes fill a buffer.
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_B1_WR, `SFC_OP_B2_WR, `SFC_OP_B1_LDPGM, `SFC_OP_B2_LDPGM: is_wr_op = 1'b1;
            default: is_wr_op = 1'b0;
         endcase
      end
   endfunction

   function [1:0] rd_kind; // 1 status, 2 buffer, 3 array, 0 no read.
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_STAT_RD, `SFC_OP_STAT_RD03: rd_kind = 2'd1;
            `SFC_OP_B1_RD, `SFC_OP_B1_RD03, `SFC_OP_B2_RD, `SFC_OP_B2_RD03: rd_kind = 2'd2;
            `SFC_OP_CONT_RD, `SFC_OP_CONT_RD03, `SFC_OP_PAGE_RD, `SFC_OP_PAGE_RD03: rd_kind = 2'd3;
            default: rd_kind = 2'd0;
         endcase
      end
   endfunction

   function op_buf;       // Buffer that an opcode uses: 1 means buffer 2.
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_B2_RD, `SFC_OP_B2_RD03, `SFC_OP_B2_WR, `SFC_OP_B2_PGM_E, `SFC_OP_B2_PGM,
            `SFC_OP_B2_LDPGM, `SFC_OP_B2_XFER, `SFC_OP_B2_CMP, `SFC_OP_B2_REWR: op_buf = 1'b1;
            default: op_buf = 1'b0;
         endcase
      end
   endfunction

   // Two-flop synchronisers, then one more stage for edge detection.
   reg  [2:0] cs_s_q;
   reg  [2:0] sck_s_q;
   reg  [1:0] si_s_q;
   reg  [1:0] wp_s_q;
   reg  [1:0] rst_s_q;
   wire       cs_fall  = ~cs_s_q[1] & cs_s_q[2];
   wire       cs_rise  = cs_s_q[1] & ~cs_s_q[2];
   wire       selected = ~cs_s_q[1];
   wire       sck_rise = selected & sck_s_q[1] & ~sck_s_q[2];
   wire       sck_fall = selected & ~sck_s_q[1] & sck_s_q[2];
   wire       hold_rst = rst_i | ~rst_s_q[1];

   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         cs_s_q  <= 3'b111;
         sck_s_q <= 3'b111;
         si_s_q  <= 2'b00;
         wp_s_q  <= 2'b11;
         rst_s_q <= 2'b11;
      end
      else
      begin
         cs_s_q  <= {cs_s_q[1:0], cs_n_i};
         sck_s_q <= {sck_s_q[1:0], sck_i};
         si_s_q  <= {si_s_q[0], si_i};
         wp_s_q  <= {wp_s_q[0], wp_n_i};
         rst_s_q <= {rst_s_q[0], reset_n_i};
      end
   end

   // Frame state.
   reg  [6:0]  bitcnt_q;
   reg  [30:0] shreg_q;
   reg  [7:0]  op_q;
   reg  [22:0] addr_q;
   reg         frame_q;
   reg  [2:0]  outbit_q;
   reg  [7:0]  oshift_q;
   reg  [9:0]  rd_col_q;
   reg         fetch_q;
   reg  [7:0]  rdata_q;
   reg  [9:0]  wr_col_q;
   reg  [2:0]  wbit_q;
   reg         push_q;
   reg  [FW-1:0] push_data_q;
   reg         busy_q;
   reg         busy_buf_q;
   reg         cmp_q;
   reg  [7:0]  mem_q [0:2*BUF_BYTES-1];
   wire        in_ready;
   wire [FW-1:0] fifo_dout;
   wire        fifo_valid;
   wire        drain_ready = ~fetch_q;                    // Buffer reads win the memory port.
   wire [7:0]  rx_byte = {shreg_q[6:0], si_s_q[1]};
   wire [1:0]  kind = rd_kind(op_q);
   wire        blocked = busy_q & (busy_buf_q == op_buf(op_q));
   wire        rd_phase = (kind == 2'd1 && bitcnt_q >= `SFC_OP_BITS) ||
                          (kind == 2'd2 && bitcnt_q >= `SFC_BUF_RD_START && !blocked) ||
                          (kind == 2'd3 && bitcnt_q >= `SFC_ARR_RD_START && !busy_q);
   wire [7:0]  status = {~busy_q, cmp_q, ST_LOW_BITS};
   wire [10:0] fetch_idx = {1'b0, rd_col_q} + (op_buf(op_q) ? BUF_BYTES[10:0] : 11'h000);
   wire [10:0] drain_idx = {1'b0, fifo_dout[9:0]} + (fifo_dout[18] ? BUF_BYTES[10:0] : 11'h000);
   wire        prot_hit = ~wp_s_q[1] &
                          (addr_q[`SFC_PAGE_LSB+`SFC_PROT_MSB:`SFC_PAGE_LSB+`SFC_PROT_LSB] == 5'h00);

   // Serial shifter: bits in on rises, opcode then address, then data bytes.
   always @(posedge mclk_i)
   begin
      if (hold_rst || cs_fall)
      begin
         bitcnt_q <= 7'h00;
         shreg_q  <= 31'h0000_0000;
         op_q     <= 8'h00;
         addr_q   <= 23'h00_0000;
         frame_q  <= cs_fall & ~hold_rst;
         wbit_q   <= 3'h0;
         wr_col_q <= 10'h000;
      end
      else if (sck_rise && frame_q)
      begin
         shreg_q <= {shreg_q[29:0], si_s_q[1]};
         if (bitcnt_q != `SFC_BITCNT_MAX)
            bitcnt_q <= bitcnt_q + 1'b1;
         if (bitcnt_q == `SFC_OP_BITS - 1'b1)
            op_q <= rx_byte;
         if (bitcnt_q == `SFC_CMD_BITS - 1'b1)
         begin
            addr_q   <= {shreg_q[21:0], si_s_q[1]};
            wr_col_q <= {shreg_q[8:0], si_s_q[1]};
         end
         if (bitcnt_q >= `SFC_CMD_BITS)
            wbit_q <= wbit_q + 1'b1;
         if (bitcnt_q >= `SFC_CMD_BITS && wbit_q == 3'h7 && is_wr_op(op_q))
            wr_col_q <= (wr_col_q == BUF_BYTES[9:0] - 1'b1) ? 10'h000 : wr_col_q + 1'b1;
      end
      else if (cs_rise)
         frame_q <= 1'b0;
   end

   // A completed data byte waits here until the FIFO takes it.
   always @(posedge mclk_i)
   begin
      if (hold_rst)
      begin
         push_q      <= 1'b0;
         push_data_q <= {FW{1'b0}};
      end
      else if (sck_rise && frame_q && bitcnt_q >= `SFC_CMD_BITS && wbit_q == 3'h7 &&
               is_wr_op(op_q) && !blocked)
      begin
         push_q      <= 1'b1;
         push_data_q <= {op_buf(op_q), rx_byte, wr_col_q};
      end
      else if (in_ready)
         push_q <= 1'b0;
   end

   sfc_fifo #(.W(FW), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo
   (
      .mclk_i      (mclk_i),
      .rst_i       (hold_rst),
      .in_data_i   (push_data_q),
      .in_valid_i  (push_q),
      .in_ready_o  (in_ready),
      .out_data_o  (fifo_dout),
      .out_valid_o (fifo_valid),
      .out_ready_i (drain_ready)
   );

   // Single-port buffer memory: read fetches or FIFO drain writes.
   always @(posedge mclk_i)
   begin
      if (fetch_q)
         rdata_q <= mem_q[fetch_idx];
      else if (fifo_valid)
         mem_q[drain_idx] <= fifo_dout[17:10];
   end

   // Output shifter: bytes launched MSB first on clock falls.
   always @(posedge mclk_i)
   begin
      if (hold_rst || !frame_q)
      begin
         so_o        <= 1'b0;
         so_oe_n_o   <= 1'b1;
         outbit_q    <= 3'h0;
         oshift_q    <= 8'h00;
         rd_col_q    <= 10'h000;
         fetch_q     <= 1'b0;
         arr_rnext_o <= 1'b0;
         arr_rd_o    <= 1'b0;
      end
      else
      begin
         fetch_q     <= 1'b0;
         arr_rnext_o <= 1'b0;
         arr_rd_o    <= (kind == 2'd3) && bitcnt_q >= `SFC_CMD_BITS && !busy_q;
         if (sck_rise && bitcnt_q == `SFC_CMD_BITS - 1'b1)
         begin
            rd_col_q <= {shreg_q[8:0], si_s_q[1]};
            fetch_q  <= 1'b1;
         end
         if (sck_fall && rd_phase)
         begin
            so_oe_n_o <= 1'b0;
            outbit_q  <= outbit_q + 1'b1;
            if (outbit_q == 3'h0)
            begin
               case (kind)
                  2'd1:    begin so_o <= status[7]; oshift_q <= {status[6:0], 1'b0}; end
                  2'd2:    begin so_o <= rdata_q[7]; oshift_q <= {rdata_q[6:0], 1'b0}; end
                  default: begin so_o <= arr_rdata_i[7]; oshift_q <= {arr_rdata_i[6:0], 1'b0}; end
               endcase
               if (kind == 2'd2)
               begin
                  rd_col_q <= (rd_col_q == BUF_BYTES[9:0] - 1'b1) ? 10'h000 : rd_col_q + 1'b1;
                  fetch_q  <= 1'b1;
               end
               arr_rnext_o <= (kind == 2'd3);
            end
            else
            begin
               so_o     <= oshift_q[7];
               oshift_q <= {oshift_q[6:0], 1'b0};
            end
         end
      end
   end

   // Clock mode is taken from the idle clock level at each select fall.
   always @(posedge mclk_i)
   begin
      if (hold_rst)
         mode3_o <= 1'b1;
      else if (cs_fall)
         mode3_o <= sck_s_q[1];
   end

   // Array scheduling: start on select rise, busy until the engine reports done.
   always @(posedge mclk_i)
   begin
      if (hold_rst)
      begin
         busy_q      <= 1'b0;
         busy_buf_q  <= 1'b0;
         cmp_q       <= 1'b0;
         arr_start_o <= 1'b0;
         arr_cmd_o   <= 8'h00;
         arr_page_o  <= 13'h0000;
         arr_col_o   <= 10'h000;
         arr_buf_o   <= 1'b0;
         rdy_o       <= 1'b0;
         rdy_oe_n_o  <= 1'b1;
      end
      else
      begin
         arr_start_o <= 1'b0;
         if (cs_rise && frame_q && bitcnt_q >= `SFC_CMD_BITS && is_busy_op(op_q) &&
             !busy_q && !(is_prog_op(op_q) && prot_hit) &&
             !(is_wr_op(op_q) && (push_q || fifo_valid)))
         begin
            busy_q      <= 1'b1;
            busy_buf_q  <= op_buf(op_q);
            arr_start_o <= 1'b1;
            arr_cmd_o   <= op_q;
            arr_page_o  <= addr_q[`SFC_PAGE_MSB:`SFC_PAGE_LSB];
            arr_col_o   <= addr_q[`SFC_COL_MSB:`SFC_COL_LSB];
            arr_buf_o   <= op_buf(op_q);
         end
         else if (busy_q && arr_done_i)
         begin
            busy_q <= 1'b0;
            if (arr_cmd_o == `SFC_OP_B1_CMP || arr_cmd_o == `SFC_OP_B2_CMP)
               cmp_q <= ~arr_match_i;
         end
         if (kind == 2'd3 && bitcnt_q == `SFC_CMD_BITS && frame_q && !busy_q)
         begin
            arr_cmd_o  <= op_q;
            arr_page_o <= addr_q[`SFC_PAGE_MSB:`SFC_PAGE_LSB];
            arr_col_o  <= addr_q[`SFC_COL_MSB:`SFC_COL_LSB];
         end
         rdy_oe_n_o <= ~(busy_q & ~arr_done_i) & ~arr_start_o;
      end
   end
endmodule
`default_nettype wire

// file: test/sfc_front_end_chk.sv
// Checker for the command front end; it sees only the top module's pins.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sfc_front_end_chk
#(
   parameter       BUF_BYTES   = 528,
   parameter       FIFO_DEPTH  = 8,
   parameter [5:0] ST_LOW_BITS = 6'h00
)
(
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        cs_n_i,
   input wire logic        sck_i,
   input wire logic        si_i,
   input wire logic        wp_n_i,
   input wire logic        reset_n_i,
   input wire logic        so_o,
   input wire logic        so_oe_n_o,
   input wire logic        rdy_o,
   input wire logic        rdy_oe_n_o,
   input wire logic        mode3_o,
   input wire logic        arr_start_o,
   input wire logic [7:0]  arr_cmd_o,
   input wire logic [12:0] arr_page_o,
   input wire logic [9:0]  arr_col_o,
   input wire logic        arr_buf_o,
   input wire logic        arr_rd_o,
   input wire logic        arr_rnext_o,
   input wire logic [7:0]  arr_rdata_i,
   input wire logic        arr_done_i,
   input wire logic        arr_match_i
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // A held reset pin keeps the pins quiet and starts nothing.
   property p_lock; !reset_n_i [*5] |-> rdy_oe_n_o && so_oe_n_o && !arr_start_o; endproperty
   a_lock: assert property (p_lock) else $error("reset pin does not hold idle");
   // Deselected, the output stays floating.
   property p_desel; cs_n_i [*8] |-> so_oe_n_o; endproperty
   a_desel: assert property (p_desel) else $error("output driven while deselected");
   // The output is only enabled inside a frame.
   property p_oe; $fell(so_oe_n_o) |-> !cs_n_i && $past(!cs_n_i, 2); endproperty
   a_oe: assert property (p_oe) else $error("output enabled outside a frame");
   // Output bits move only a few cycles after a falling serial clock.
   property p_edge; $changed(so_o) && !so_oe_n_o && $past(!so_oe_n_o) |-> $past(!sck_i, 2); endproperty
   a_edge: assert property (p_edge) else $error("output bit moved off the falling edge");
   // Every start pulls the busy pin low on the next edge.
   property p_busy; arr_start_o |=> !rdy_oe_n_o; endproperty
   a_busy: assert property (p_busy) else $error("busy pin not pulled after start");
   // The busy pin is released within two edges of done.
   property p_free; arr_done_i && !rdy_oe_n_o |-> ##[1:2] rdy_oe_n_o; endproperty
   a_free: assert property (p_free) else $error("busy pin not released after done");
   // No second array operation starts while busy.
   property p_one; !rdy_oe_n_o |-> !arr_start_o; endproperty
   a_one: assert property (p_one) else $error("array start while busy");
   // The mode follows the idle clock level seen at select fall.
   property p_mode; reset_n_i [*6] ##0 $changed(mode3_o) |-> !cs_n_i && mode3_o == sck_i; endproperty
   a_mode: assert property (p_mode) else $error("clock mode not taken at select fall");
   // With protect low, no program or erase other than a rewrite starts below page 256.
   property p_prot; arr_start_o && !wp_n_i && $past(!wp_n_i, 4) &&
      arr_cmd_o inside {8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85, 8'h81, 8'h50} |-> arr_page_o[12:8] != 5'h00;
   endproperty
   a_prot: assert property (p_prot) else $error("protected page started");
   // Each array byte request comes with the read level up and the output driven.
   property p_rnext; arr_rnext_o |-> arr_rd_o && !so_oe_n_o; endproperty
   a_rnext: assert property (p_rnext) else $error("array byte taken outside a read");
endmodule
`default_nettype wire

// file: test/sfc_host_model.sv
// Host model: frames commands on select, serial clock and data in, samples the reply.
// Assumes the system clock; every pin change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model
(
   input  wire logic mclk_i,
   output var  logic cs_n_o,
   output var  logic sck_o,
   output var  logic si_o,
   input  wire logic so_i,
   input  wire logic so_oe_n_i
);
   logic act_q;
   // Pins start deselected with the clock idling high.
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      si_o = 1'b0;
      act_q = 1'b0;
   end
   // Outside frames the data line toggles so a stale bit is never taken as input.
   always @(posedge mclk_i)
   begin
      if (!act_q)
         si_o <= ~si_o;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // One frame of 160 ns clocks; each bit opens with a fall and samples the reply after the rise.
   task automatic frame(input logic m3, input logic [7:0] op, input logic [23:0] ad, input int na,
                        input int nd, input int nw, input logic [7:0] wd, input int nr,
                        output logic [7:0] rd, output logic seen);
      logic [63:0] sh;
      int          n;
      sh = {op, ad, 32'h0000_0000};
      n = 8 + na + nd;
      rd = 8'h00;
      seen = 1'b0;
      act_q <= 1'b1;
      sck_o <= m3;
      wt(4);
      cs_n_o <= 1'b0;
      wt(8);
      for (int i = 0; i < n + nw + nr; i++)
      begin
         sck_o <= 1'b0;
         si_o <= (i < n) ? sh[63 - i] : (i < n + nw) ? wd[7 - (i - n)] : ~si_o;
         wt(4);
         sck_o <= 1'b1;
         wt(1);
         if (i >= n + nw)
         begin
            rd = {rd[6:0], so_oe_n_i ? ~so_i : so_i}; // A released line never shows a stale bit.
            seen = seen | !so_oe_n_i;
         end
         wt(3);
      end
      sck_o <= m3;
      wt(4);
      cs_n_o <= 1'b1;
      act_q <= 1'b0;
      wt(10);
   endtask
endmodule
`default_nettype wire

// file: test/serial_flash_command_front_end_bench.sv
// Bench for the command front end: host model on the pins, array engine modelled here.
// Assumes a 50 MHz system clock; expectations come from the opcode tables.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"
module serial_flash_command_front_end_bench;
   localparam logic [5:0] ST_LOW = 6'h2A;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cs_n_i, sck_i, si_i, so_o, so_oe_n_o, rdy_o, rdy_oe_n_o, mode3_o;
   logic        wp_n_i = 1'b1, reset_n_i = 1'b1, arr_done_i = 1'b0, arr_match_i = 1'b0;
   logic        arr_start_o, arr_buf_o, arr_rd_o, arr_rnext_o;
   logic [7:0]  arr_rdata_i = 8'h00, arr_cmd_o, rd, d;
   logic [12:0] arr_page_o, pg;
   logic [9:0]  arr_col_o, c;
   logic        hold = 1'b0, mt = 1'b0, m3, seen, cmp_q = 1'b0;
   logic [8:0]  e;
   int          failures = 0, checks_done = 0, n_start = 0, dly = 0, k, n0;
   logic [8:0]  tbl [14] = '{9'h060, 9'h161, 9'h053, 9'h155, 9'h058, 9'h159, 9'h083,
                             9'h186, 9'h088, 9'h189, 9'h082, 9'h185, 9'h081, 9'h050};
   logic [7:0]  rops [4] = '{8'h68, 8'hE8, 8'h52, 8'hD2};
   always #10 mclk_i = ~mclk_i;
   sfc_front_end #(.ST_LOW_BITS(ST_LOW)) dut_u (.*);
   sfc_host_model host_u (.mclk_i(mclk_i), .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i),
                          .so_i(so_o), .so_oe_n_i(so_oe_n_o));
   // Array engine: answers each start not cut off by the reset pin with done after a random delay, never while held.
   always @(posedge mclk_i)
   begin
      arr_match_i <= mt;
      arr_done_i <= !arr_start_o && reset_n_i && !hold && dly == 1;
      if (arr_start_o)
         dly <= 3 + $urandom % 20;
      else if (!reset_n_i)
         dly <= 0;
      else if (dly > 0 && !hold)
         dly <= dly - 1;
      if (arr_start_o)
         n_start <= n_start + 1;
   end
   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks_done++;
      if (seen_v !== exp_v)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic fr(input logic [7:0] op, input logic [23:0] ad, input int nd, input int nw,
                     input logic [7:0] wd, input int nr);
      m3 = ($urandom % 2) == 1;
      host_u.frame(m3, op, ad, 24, nd, nw, wd, nr, rd, seen);
   endtask
   task automatic st(input logic [7:0] exp);
      m3 = ($urandom % 2) == 1;
      host_u.frame(m3, m3 ? `SFC_OP_STAT_RD : `SFC_OP_STAT_RD03, 24'h00_0000, 0, 0, 0, 8'h00, 8, rd, seen);
      chk({seen, rd}, {1'b1, exp});
   endtask
   task automatic wait_start(input logic exp);
      for (int i = 0; i < 40 && n_start == n0; i++) @(posedge mclk_i);
      chk(n_start != n0, exp);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200 && rdy_oe_n_o !== 1'b1; i++) @(posedge mclk_i);
      chk(rdy_oe_n_o, 1'b1);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog: cuts a hang short well past the expected run length.
   initial
   begin
      #1_200_000;
      failures++;
      report_and_stop();
   end
   // Main sequence: reset, every array command, buffer traffic while busy, protection, reset pin, reads.
   initial
   begin
      void'($urandom(85));
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      chk({so_oe_n_o, rdy_oe_n_o, mode3_o}, 3'b111);
      for (k = 0; k < 14; k++)
      begin
         e = tbl[k];
         pg = 13'(256 + $urandom % 7936);
         if (e[7:0] == `SFC_OP_BLK_ERASE)
            pg[2:0] = 3'h0;
         hold = 1'b1;
         mt = ($urandom % 2) == 1;
         n0 = n_start;
         fr(e[7:0], {1'b0, pg, 10'h000}, 0, 0, 8'h00, 0);
         wait_start(1'b1);
         chk({arr_cmd_o, arr_page_o, mode3_o}, {e[7:0], pg, m3});
         if (e[7:0] != `SFC_OP_PAGE_ERASE && e[7:0] != `SFC_OP_BLK_ERASE)
            chk(arr_buf_o, e[8]);
         st({1'b0, cmp_q, ST_LOW});
         chk({rdy_oe_n_o, rdy_o}, 2'b00);
         hold = 1'b0;
         wait_idle();
         if (e[7:1] == 7'h30)
            cmp_q = !mt;
         st({1'b1, cmp_q, ST_LOW});
      end
      // Buffer 1 stays open while a buffer 2 program is held busy.
      hold = 1'b1;
      n0 = n_start;
      fr(`SFC_OP_B2_PGM_E, {1'b0, pg, 10'h000}, 0, 0, 8'h00, 0);
      wait_start(1'b1);
      c = 10'($urandom % 528);
      d = 8'($urandom);
      fr(`SFC_OP_B1_WR, {14'h0000, c}, 0, 8, d, 0);
      fr(m3 ? `SFC_OP_B1_RD : `SFC_OP_B1_RD03, {14'h0000, c}, 8, 0, 8'h00, 8);
      chk({seen, rd}, {1'b1, d});
      fr(`SFC_OP_B2_RD, {14'h0000, c}, 8, 0, 8'h00, 8);
      chk(seen, 1'b0);
      n0 = n_start;
      fr(`SFC_OP_B1_XFER, {1'b0, pg, 10'h000}, 0, 0, 8'h00, 0);
      wait_start(1'b0);
      hold = 1'b0;
      wait_idle();
      fr(`SFC_OP_B2_WR, {14'h0000, c}, 0, 8, ~d, 0);
      fr(`SFC_OP_B2_RD03, {14'h0000, c}, 8, 0, 8'h00, 8);
      chk({seen, rd}, {1'b1, ~d});
      // Protect low refuses page 255 and accepts page 256.
      wp_n_i <= 1'b0;
      n0 = n_start;
      fr(`SFC_OP_B1_PGM, {1'b0, 13'h00FF, 10'h000}, 0, 0, 8'h00, 0);
      wait_start(1'b0);
      fr(`SFC_OP_B1_PGM, {1'b0, 13'h0100, 10'h000}, 0, 0, 8'h00, 0);
      wait_start(1'b1);
      wp_n_i <= 1'b1;
      wait_idle();
      // The reset pin aborts a held erase and restores mode 3.
      hold = 1'b1;
      n0 = n_start;
      fr(`SFC_OP_PAGE_ERASE, {1'b0, 13'h0200, 10'h000}, 0, 0, 8'h00, 0);
      wait_start(1'b1);
      reset_n_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      chk({rdy_oe_n_o, so_oe_n_o, mode3_o}, 3'b111);
      reset_n_i <= 1'b1;
      hold = 1'b0;
      repeat (8) @(posedge mclk_i);
      cmp_q = 1'b0; // The reset pin clears the compare flag as well.
      st({1'b1, cmp_q, ST_LOW});
      // Array reads stream the engine's byte after the dummy bits.
      for (k = 0; k < 4; k++)
      begin
         arr_rdata_i <= 8'($urandom);
         @(posedge mclk_i);
         fr(rops[k], {1'b0, pg, c}, 32, 0, 8'h00, 8);
         chk({seen, rd, arr_cmd_o, arr_col_o}, {1'b1, arr_rdata_i, rops[k], c});
      end
      report_and_stop();
   end
endmodule
bind sfc_front_end sfc_front_end_chk #(.BUF_BYTES(BUF_BYTES), .FIFO_DEPTH(FIFO_DEPTH),
   .ST_LOW_BITS(ST_LOW_BITS)) chk_u (.*);
`default_nettype wire
